/* core/hcr_engine.sv */
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "hcr_params.svh"

// Notes on behaviour
// - Address-device with flag clear: controller itself sends SET_ADDRESS with assigned address.
// - Software SET_ADDRESS setup on endpoint zero is blocked with ring-block error.
// - Unrecognised block type completes with ring-block error.
// - One command ring; software produces, controller consumes, only defined types.
// - Dequeue pointer is internal, reported only in events, loaded from control register.
// - Each descriptor is one command block; software queues then rings doorbell.
// - After a doorbell, fetch and execute in order until empty or stopped.
// - One completion event per command with pointer, code, slot and function id.
// - Completion events follow ring order.
// - Vendor commands complete through the standard completion event.
// - Stop bit: finish current command, fetch no more, post ring-stopped with pointer.
// - Restart at newly written pointer, else at current dequeue pointer.
// - Abort during a command: post aborted, advance, then always post ring-stopped.
// - Abort between commands may post only ring-stopped.
module hcr_engine
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mem_req,
  output logic [63:0] mem_addr,
  input wire logic mem_ack,
  input wire hcr_pkg::hcr_cmd_t mem_cmd,
  output logic exec_start,
  output hcr_pkg::hcr_cmd_t exec_cmd,
  output logic exec_abort,
  input wire logic exec_done,
  input wire logic [7:0] exec_code,
  input wire logic [6:0] exec_dev_addr,
  output logic setaddr_req,
  output logic [6:0] setaddr_addr,
  input wire logic setaddr_ack,
  output logic evt_valid,
  output hcr_pkg::hcr_evt_t evt_data,
  input wire logic evt_ready,
  input wire logic setup_valid,
  input wire logic [3:0] setup_ep,
  input wire logic [7:0] setup_req_type,
  input wire logic [7:0] setup_request,
  output logic setup_pass,
  output logic setup_block,
  output logic [7:0] setup_code,
  output logic ring_running_flag
);
  import hcr_pkg::*;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic is_vendor(input logic [5:0] t);
    is_vendor = t >= `HCR_TYPE_VEND_FIRST && t <= `HCR_TYPE_VEND_LAST;
  endfunction

  function automatic logic is_known(input logic [5:0] t);
    is_known = (t >= `HCR_TYPE_STD_FIRST && t <= `HCR_TYPE_STD_LAST) || is_vendor(t);
  endfunction

  function automatic logic needs_setaddr(input hcr_cmd_t c);
    needs_setaddr = c.blk_type == `HCR_TYPE_ADDR_DEV && !c.block_set_address_flag;
  endfunction

  hcr_state_t state_r;
  hcr_cmd_t cmd_r;
  hcr_evt_t evt_r;
  logic [63:0] deq_r;
  logic cycle_r;
  logic running_r;
  logic stop_pend_r;
  logic abort_pend_r;
  logic exec_start_r;
  logic [6:0] setaddr_addr_r;
  logic [7:0] last_code_r;
  logic [31:0] rdata_r;
  logic ctrl_lo_wr;
  logic ctrl_hi_wr;
  logic doorbell_hit;
  logic fetch_take;
  logic post_take;
  logic stop_take;
  logic ring_empty;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  assign ctrl_lo_wr = reg_wr && reg_addr == `HCR_OFS_CTRL_LO;
  assign ctrl_hi_wr = reg_wr && reg_addr == `HCR_OFS_CTRL_HI;
  assign doorbell_hit = reg_wr && reg_addr == `HCR_OFS_DOORBELL
                        && reg_wdata[`HCR_DOORBELL_TARGET_FIELD_MSB:0] == `HCR_DOORBELL_TARGET_FIELD_HOST_CMD
                        && reg_wdata[31:`HCR_DB_STREAM_LSB] == `HCR_DB_STREAM_ZERO;

  assign fetch_take = state_r == ST_FETCH && mem_ack;
  assign ring_empty = mem_cmd.cycle != cycle_r;
  assign post_take = state_r == ST_POST && evt_ready;
  assign stop_take = state_r == ST_STOP && evt_ready;

  // ----------------------------------------------------------------------
  // Handshake outputs
  // ----------------------------------------------------------------------
  assign mem_req = state_r == ST_FETCH && !stop_pend_r && !abort_pend_r;
  assign mem_addr = deq_r;
  assign exec_start = exec_start_r;
  assign exec_cmd = cmd_r;
  assign exec_abort = (state_r == ST_EXEC || state_r == ST_SETADDR) && abort_pend_r;
  assign setaddr_req = state_r == ST_SETADDR;
  assign setaddr_addr = setaddr_addr_r;
  assign evt_valid = state_r == ST_POST || state_r == ST_STOP;
  assign evt_data = evt_r;
  assign reg_rdata = rdata_r;
  assign ring_running_flag = running_r;

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `HCR_OFS_CTRL_LO: rdata_r <= {28'h000_0000, running_r, 3'h0};
        `HCR_OFS_STATUS: rdata_r <= {24'h00_0000, last_code_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
    else
    begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Dequeue pointer and consumer cycle state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      deq_r <= 64'h0000_0000_0000_0000;
      cycle_r <= 1'b0;
    end
    else if (post_take)
    begin
      deq_r <= deq_r + `HCR_BLOCK_BYTES;
    end
    else if (!running_r && ctrl_lo_wr)
    begin
      deq_r[31:0] <= {reg_wdata[31:`HCR_PTR_LSB], 6'h00};
      cycle_r <= reg_wdata[`HCR_CTRL_CYCLE_BIT];
    end
    else if (!running_r && ctrl_hi_wr)
    begin
      deq_r[63:32] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Stop and abort requests
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stop_pend_r <= 1'b0;
      abort_pend_r <= 1'b0;
    end
    else
    begin
      if (running_r && ctrl_lo_wr && reg_wdata[`HCR_CTRL_STOP_BIT])
      begin
        stop_pend_r <= 1'b1;
      end
      else if (stop_take)
      begin
        stop_pend_r <= 1'b0;
      end
      if (running_r && ctrl_lo_wr && reg_wdata[`HCR_CTRL_ABORT_BIT])
      begin
        abort_pend_r <= 1'b1;
      end
      else if (stop_take)
      begin
        abort_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Running flag
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      running_r <= 1'b0;
    end
    else if (stop_take)
    begin
      running_r <= 1'b0;
    end
    else if (doorbell_hit)
    begin
      running_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      cmd_r <= '0;
      evt_r <= '0;
      exec_start_r <= 1'b0;
      setaddr_addr_r <= 7'h00;
      last_code_r <= 8'h00;
    end
    else
    begin
      exec_start_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (doorbell_hit)
          begin
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          if (stop_pend_r || abort_pend_r)
          begin
            state_r <= ST_STOP;
            evt_r <= '{ptr: deq_r, code: `HCR_CC_RING_STOPPED, slot: 8'h00, vf: 8'h00};
          end
          else if (fetch_take)
          begin
            cmd_r <= mem_cmd;
            if (ring_empty)
            begin
              state_r <= ST_WAIT;
            end
            else if (is_known(mem_cmd.blk_type))
            begin
              state_r <= ST_EXEC;
              exec_start_r <= 1'b1;
            end
            else
            begin
              state_r <= ST_POST;
              evt_r <= '{ptr: deq_r, code: `HCR_CC_BLOCK_ERR, slot: mem_cmd.slot, vf: mem_cmd.vf};
            end
          end
        end
        ST_EXEC:
        begin
          if (abort_pend_r)
          begin
            state_r <= ST_POST;
            evt_r <= '{ptr: deq_r, code: `HCR_CC_ABORTED, slot: cmd_r.slot, vf: cmd_r.vf};
          end
          else if (exec_done)
          begin
            if (needs_setaddr(cmd_r) && exec_code == `HCR_CC_SUCCESS)
            begin
              state_r <= ST_SETADDR;
              setaddr_addr_r <= exec_dev_addr;
            end
            else
            begin
              state_r <= ST_POST;
              evt_r <= '{ptr: deq_r, code: exec_code, slot: cmd_r.slot, vf: cmd_r.vf};
            end
          end
        end
        ST_SETADDR:
        begin
          if (abort_pend_r)
          begin
            state_r <= ST_POST;
            evt_r <= '{ptr: deq_r, code: `HCR_CC_ABORTED, slot: cmd_r.slot, vf: cmd_r.vf};
          end
          else if (setaddr_ack)
          begin
            state_r <= ST_POST;
            evt_r <= '{ptr: deq_r, code: `HCR_CC_SUCCESS, slot: cmd_r.slot, vf: cmd_r.vf};
          end
        end
        ST_POST:
        begin
          if (evt_ready)
          begin
            last_code_r <= evt_r.code;
            if (evt_r.code == `HCR_CC_ABORTED)
            begin
              state_r <= ST_STOP;
              evt_r <= '{ptr: deq_r + `HCR_BLOCK_BYTES, code: `HCR_CC_RING_STOPPED, slot: 8'h00, vf: 8'h00};
            end
            else
            begin
              state_r <= ST_FETCH;
            end
          end
        end
        ST_STOP:
        begin
          if (evt_ready)
          begin
            last_code_r <= evt_r.code;
            state_r <= ST_IDLE;
          end
        end
        ST_WAIT:
        begin
          if (stop_pend_r || abort_pend_r)
          begin
            state_r <= ST_STOP;
            evt_r <= '{ptr: deq_r, code: `HCR_CC_RING_STOPPED, slot: 8'h00, vf: 8'h00};
          end
          else if (doorbell_hit)
          begin
            state_r <= ST_FETCH;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Setup stage filter
  // ----------------------------------------------------------------------
  hcr_setup_filter u_setup_filter
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .setup_valid(setup_valid),
    .setup_ep(setup_ep),
    .setup_req_type(setup_req_type),
    .setup_request(setup_request),
    .setup_pass(setup_pass),
    .setup_block(setup_block),
    .setup_code(setup_code)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_UNKNOWN_TYPE: assert property (@(posedge clk_sys) disable iff (!nrst)
    mem_req && mem_ack && !ring_empty && !is_known(mem_cmd.blk_type)
    |=> state_r == ST_POST && evt_data.code == `HCR_CC_BLOCK_ERR)
    else $error("Unknown block type not completed with ring-block error");

  AST_SETADDR_ISSUE: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_r == ST_EXEC && !abort_pend_r && exec_done && needs_setaddr(cmd_r) && exec_code == `HCR_CC_SUCCESS
    |=> setaddr_req && setaddr_addr == $past(exec_dev_addr))
    else $error("Controller did not issue SET_ADDRESS");

  AST_EVT_FIELDS: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_r == ST_POST |-> evt_data.ptr == deq_r && evt_data.slot == cmd_r.slot && evt_data.vf == cmd_r.vf)
    else $error("Completion event fields do not match the command");

  AST_ORDER: assert property (@(posedge clk_sys) disable iff (!nrst)
    post_take |=> deq_r == $past(deq_r) + `HCR_BLOCK_BYTES)
    else $error("Dequeue pointer did not advance by one block");

  AST_STOP_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_r == ST_STOP |-> evt_valid && evt_data.code == `HCR_CC_RING_STOPPED && evt_data.ptr == deq_r)
    else $error("Ring-stopped event wrong");

  AST_NO_FETCH_STOP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (stop_pend_r || abort_pend_r) && state_r == ST_FETCH |-> !mem_req ##1 state_r == ST_STOP)
    else $error("Fetch while stop pending");

  AST_ABORT_EXEC: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_r == ST_EXEC && abort_pend_r |=> state_r == ST_POST && evt_data.code == `HCR_CC_ABORTED
    ##[1:1000] state_r == ST_STOP)
    else $error("Abort sequence wrong");

  AST_RUNNING_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
    stop_take |=> !ring_running_flag && state_r == ST_IDLE)
    else $error("Running flag not cleared after ring-stopped");

  AST_RESUME_PTR: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_lo_wr && !running_r && state_r == ST_IDLE |=> deq_r[31:0] == {$past(reg_wdata[31:`HCR_PTR_LSB]), 6'h00})
    else $error("Ring pointer write not loaded");

endmodule

/* inc/hcr_params.svh */
`ifndef HCR_PARAMS_SVH
`define HCR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define HCR_OFS_CTRL_LO 8'h00
`define HCR_OFS_CTRL_HI 8'h04
`define HCR_OFS_DOORBELL 8'h08
`define HCR_OFS_STATUS 8'h0C

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define HCR_CTRL_CYCLE_BIT 0
`define HCR_CTRL_STOP_BIT 1
`define HCR_CTRL_ABORT_BIT 2
`define HCR_CTRL_RUN_BIT 3
`define HCR_PTR_LSB 6
`define HCR_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// Doorbell fields
// ----------------------------------------------------------------------
`define HCR_DOORBELL_TARGET_FIELD_MSB 7
`define HCR_DB_STREAM_LSB 16
`define HCR_DOORBELL_TARGET_FIELD_HOST_CMD 8'h00
`define HCR_DB_STREAM_ZERO 16'h0000

// ----------------------------------------------------------------------
// Ring geometry
// ----------------------------------------------------------------------
`define HCR_BLOCK_BYTES 64'h0000_0000_0000_0010

// ----------------------------------------------------------------------
// Block type codes
// ----------------------------------------------------------------------
`define HCR_TYPE_STD_FIRST 6'h09
`define HCR_TYPE_STD_LAST 6'h17
`define HCR_TYPE_ADDR_DEV 6'h0B
`define HCR_TYPE_VEND_FIRST 6'h30
`define HCR_TYPE_VEND_LAST 6'h3F

// ----------------------------------------------------------------------
// Completion codes
// ----------------------------------------------------------------------
`define HCR_CC_SUCCESS 8'h01
`define HCR_CC_BLOCK_ERR 8'h02
`define HCR_CC_ABORTED 8'h03
`define HCR_CC_RING_STOPPED 8'h04

// ----------------------------------------------------------------------
// Setup request that the controller reserves to itself
// ----------------------------------------------------------------------
`define HCR_SETUP_DEFAULT_EP 4'h0
`define HCR_SETUP_STD_DEV_OUT 8'h00
`define HCR_SETUP_SET_ADDRESS 8'h05

`endif

/* inc/hcr_pkg.sv */
package hcr_pkg;

  // ----------------------------------------------------------------------
  // Command block as fetched from the ring
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic [5:0] blk_type;
    logic [7:0] slot;
    logic [7:0] vf;
    logic block_set_address_flag;
    logic cycle;
  } hcr_cmd_t;

  // ----------------------------------------------------------------------
  // Completion event
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic [63:0] ptr;
    logic [7:0] code;
    logic [7:0] slot;
    logic [7:0] vf;
  } hcr_evt_t;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC,
    ST_SETADDR,
    ST_POST,
    ST_STOP,
    ST_WAIT
  } hcr_state_t;

endpackage

/* core/hcr_setup_filter.sv */
`timescale 1ns/1ps
`include "hcr_params.svh"

module hcr_setup_filter
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic setup_valid,
  input wire logic [3:0] setup_ep,
  input wire logic [7:0] setup_req_type,
  input wire logic [7:0] setup_request,
  output logic setup_pass,
  output logic setup_block,
  output logic [7:0] setup_code
);
  import hcr_pkg::*;

  logic hit;

  assign hit = setup_ep == `HCR_SETUP_DEFAULT_EP && setup_req_type == `HCR_SETUP_STD_DEV_OUT
               && setup_request == `HCR_SETUP_SET_ADDRESS;

  // ----------------------------------------------------------------------
  // Pass or block each software setup stage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      setup_pass <= 1'b0;
      setup_block <= 1'b0;
      setup_code <= 8'h00;
    end
    else
    begin
      setup_pass <= setup_valid && !hit;
      setup_block <= setup_valid && hit;
      if (setup_valid)
      begin
        setup_code <= hit ? `HCR_CC_BLOCK_ERR : `HCR_CC_SUCCESS;
      end
    end
  end

  AST_SETUP_BLOCK: assert property (@(posedge clk_sys) disable iff (!nrst)
    setup_valid && hit |=> setup_block && !setup_pass && setup_code == `HCR_CC_BLOCK_ERR)
    else $error("Software SET_ADDRESS setup was not blocked");

endmodule

/* tb/hcr_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Software-side model: ring memory, executor and event consumer
// ----------------------------------------------------------------------
module hcr_host_model
#(
  parameter logic [5:0] HANG_TYPE = 6'h0C
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic stall,
  input wire hcr_pkg::hcr_cmd_t ring [16],
  input wire logic mem_req,
  input wire logic [63:0] mem_addr,
  output logic mem_ack,
  output hcr_pkg::hcr_cmd_t mem_cmd,
  input wire logic exec_start,
  input wire hcr_pkg::hcr_cmd_t exec_cmd,
  input wire logic exec_abort,
  output logic exec_done,
  output logic [7:0] exec_code,
  output logic [6:0] exec_dev_addr,
  input wire logic setaddr_req,
  output logic setaddr_ack,
  input wire logic evt_valid,
  output logic evt_ready
);
  import hcr_pkg::*;
  hcr_cmd_t job_r;
  logic busy_r;
  assign evt_ready = evt_valid && !stall;
  assign exec_dev_addr = exec_done ? job_r.slot[6:0] : ~job_r.slot[6:0];
  // One block per descriptor, written only by software
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      mem_ack <= 1'b0;
      mem_cmd <= '0;
    end
    else
    begin
      mem_ack <= mem_req && !stall && !mem_ack;
      mem_cmd <= (mem_req && !stall && !mem_ack) ? ring[mem_addr[7:4]] : ~mem_cmd;
    end
  // Executor finishes after random stalls; the slow type waits for abort
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      busy_r <= 1'b0;
      job_r <= '0;
      exec_done <= 1'b0;
      exec_code <= 8'hFE;
      setaddr_ack <= 1'b0;
    end
    else
    begin
      exec_done <= 1'b0;
      exec_code <= 8'hFE;
      setaddr_ack <= setaddr_req && !stall && !setaddr_ack;
      if (exec_start)
      begin
        busy_r <= 1'b1;
        job_r <= exec_cmd;
      end
      else if (exec_abort)
        busy_r <= 1'b0;
      else if (busy_r && !stall && job_r.blk_type != HANG_TYPE)
      begin
        busy_r <= 1'b0;
        exec_done <= 1'b1;
        exec_code <= 8'h01;
      end
    end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps

module testbench;
  import hcr_pkg::*;
  localparam logic [63:0] BASE = 64'h0000_0000_0000_1000;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic setup_valid = 1'b0;
  logic [3:0] setup_ep = 4'h0;
  logic [7:0] setup_req_type = 8'h00;
  logic [7:0] setup_request = 8'h00;
  logic stall = 1'b0;
  logic [31:0] reg_rdata;
  logic [63:0] mem_addr;
  logic mem_req, mem_ack, exec_start, exec_abort, exec_done, setaddr_req, setaddr_ack;
  logic evt_valid, evt_ready, setup_pass, setup_block, ring_running_flag;
  logic [7:0] exec_code, setup_code;
  logic [6:0] exec_dev_addr, setaddr_addr, exp_sa;
  hcr_cmd_t mem_cmd, exec_cmd;
  hcr_cmd_t ring [16];
  hcr_evt_t evt_data, got_e;
  hcr_evt_t exp_q [$];
  integer seed = 63;
  integer n_mismatch = 0;
  integer checks = 0;
  integer n_sa = 0;

  always #5 clk_sys = ~clk_sys;

  hcr_engine uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_cmd(mem_cmd), .exec_start(exec_start), .exec_cmd(exec_cmd),
    .exec_abort(exec_abort), .exec_done(exec_done), .exec_code(exec_code), .exec_dev_addr(exec_dev_addr),
    .setaddr_req(setaddr_req), .setaddr_addr(setaddr_addr), .setaddr_ack(setaddr_ack),
    .evt_valid(evt_valid), .evt_data(evt_data), .evt_ready(evt_ready), .setup_valid(setup_valid),
    .setup_ep(setup_ep), .setup_req_type(setup_req_type), .setup_request(setup_request),
    .setup_pass(setup_pass), .setup_block(setup_block), .setup_code(setup_code),
    .ring_running_flag(ring_running_flag));

  hcr_host_model pm (.clk_sys(clk_sys), .nrst(nrst), .stall(stall), .ring(ring), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_cmd(mem_cmd), .exec_start(exec_start),
    .exec_cmd(exec_cmd), .exec_abort(exec_abort), .exec_done(exec_done), .exec_code(exec_code),
    .exec_dev_addr(exec_dev_addr), .setaddr_req(setaddr_req), .setaddr_ack(setaddr_ack),
    .evt_valid(evt_valid), .evt_ready(evt_ready));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [87:0] seen, input logic [87:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp, what);
  endtask

  task automatic put(input int i, input logic [5:0] t, input logic f);
    ring[i] = {t, 8'($random(seed)), 8'($random(seed)), f, 1'b1};
  endtask

  function automatic hcr_evt_t ev(input int i, input logic [7:0] code);
    hcr_evt_t e;
    e.ptr = BASE + (64'(i) << 4);
    e.code = code;
    e.slot = ring[i].slot;
    e.vf = ring[i].vf;
    return e;
  endfunction

  task automatic drain(input string what);
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++)
      @(posedge clk_sys);
    check(exp_q.size(), 0, what);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic setup_try(input logic [3:0] ep, input logic [7:0] rt, input logic [7:0] rq);
    logic blk;
    blk = (ep == 4'h0) && (rt == 8'h00) && (rq == 8'h05);
    @(posedge clk_sys);
    setup_valid <= 1'b1;
    setup_ep <= ep;
    setup_req_type <= rt;
    setup_request <= rq;
    @(posedge clk_sys);
    setup_valid <= 1'b0;
    #1 check({setup_block, setup_pass, setup_code}, {blk, !blk, blk ? 8'h02 : 8'h01}, "setup filter");
  endtask

  // ----------------------------------------------------------------------
  // Monitors and random stalls
  // ----------------------------------------------------------------------
  always @(posedge clk_sys)
    if (nrst && evt_valid && evt_ready)
    begin
      if (exp_q.size() == 0)
        check(1'b1, 1'b0, "unexpected event");
      else
      begin
        got_e = exp_q.pop_front();
        check({evt_data.ptr, evt_data.code}, {got_e.ptr, got_e.code}, "event pointer or code");
        if (got_e.code != 8'h04)
          check({evt_data.slot, evt_data.vf}, {got_e.slot, got_e.vf}, "event ids");
      end
    end

  always @(posedge clk_sys)
    if (nrst && setaddr_req && setaddr_ack)
    begin
      n_sa++;
      check(setaddr_addr, exp_sa, "set address value");
    end

  always @(posedge clk_sys)
    stall <= ($random(seed) & 3) == 0;

  initial
  begin
    #400000;
    n_mismatch++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 16; i++)
      ring[i] = '0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h00, 32'h0000_0000, "idle flag");
    rd(8'hF0, 32'h0000_0000, "unmapped read");
    put(0, 6'h09, 1'b0);
    put(1, 6'h3F, 1'b0);
    put(2, 6'h18, 1'b0);
    put(3, 6'h0B, 1'b0);
    put(4, 6'h0B, 1'b1);
    exp_sa = ring[3].slot[6:0];
    exp_q = '{ev(0, 8'h01), ev(1, 8'h01), ev(2, 8'h02), ev(3, 8'h01), ev(4, 8'h01)};
    wr(8'h00, BASE[31:0] | 32'h0000_0001);
    wr(8'h04, BASE[63:32]);
    wr(8'h08, 32'h0000_0000);
    drain("command sequence");
    check(n_sa, 1, "set address count");
    rd(8'h00, 32'h0000_0008, "running while empty");
    check(ring_running_flag, 1'b1, "running flag pin");
    exp_q = '{ev(5, 8'h04)};
    wr(8'h00, 32'h0000_0002);
    drain("stop");
    rd(8'h00, 32'h0000_0000, "stopped flag");
    check(ring_running_flag, 1'b0, "stopped flag pin");
    wr(8'h08, 32'h0001_0000);
    rd(8'h00, 32'h0000_0000, "stream doorbell ignored");
    rd(8'h0C, 32'h0000_0004, "last code");
    put(8, 6'h0C, 1'b0);
    exp_q = '{ev(8, 8'h03), ev(9, 8'h04)};
    wr(8'h00, BASE[31:0] | 32'h0000_0081);
    wr(8'h08, 32'h0000_0000);
    repeat (20) @(posedge clk_sys);
    wr(8'h00, 32'h0000_0004);
    drain("abort in flight");
    rd(8'h00, 32'h0000_0000, "flag after abort");
    exp_q = '{ev(9, 8'h04)};
    wr(8'h08, 32'h0000_0000);
    repeat (10) @(posedge clk_sys);
    rd(8'h00, 32'h0000_0008, "resumed");
    wr(8'h00, 32'h0000_0004);
    drain("abort between commands");
    setup_try(4'h0, 8'h00, 8'h05);
    setup_try(4'h0, 8'h00, 8'h09);
    for (int i = 0; i < 12; i++)
      setup_try(4'($random(seed) & 1), 8'($random(seed) & 8'h80), 8'h05 ^ 8'($random(seed) & 8'h0C));
    complete_run();
  end
endmodule
